// >>> ook_modem_config_registers.sv
// Configuration register bank of a four-port on-off-keyed modem, reached over SPI.
// Assumes SPI mode 0 with SCLK at most one fifth of CLOCK; every pin input is
// synchronised here and the scan engine supplies its result on the same clock.
// How it works
// - Config bit 7 at 1 keeps the oscillator and reference clock running in power-down.
// - Config bit 5 at 1 switches off only the transmitter, with the PLL left running.
// - Config bit 4 at 1 forces the carrier on, at 0 the carrier follows the key pin.
// - Config bits 3:2 pick reference clock drive: off, normal, level two or three.
// - Config bits 1:0 pick 9.6, 38.4 or 115.2 kbps, and code 3 is unused.
// - Port bit 2 at 1 isolates the modem from every RF port.
// - Port bits 1:0 pick which of the four RF ports joins the common port.
`timescale 1ns/1ps

module ook_modem_config_registers #(
    parameter logic [7:0] PART_CODE     = 8'h5a, // Arbitrary value.
    parameter logic [7:0] REVISION_CODE = 8'h01  // Arbitrary value.
) (
    input  wire logic       CLOCK,
    input  wire logic       RESETN,
    input  wire logic       SPI_CS_N,
    input  wire logic       SPI_SCLK,
    input  wire logic       SPI_MOSI,
    output logic            SPI_MISO,
    output logic            SPI_MISO_OE_N,
    input  wire logic       TRANSMIT_KEY_INPUT_N,
    input  wire logic       RX_OUT_N,
    input  wire logic       DIRECTION,
    input  wire logic [7:0] SCAN_RESULT,
    output logic      [7:0] SCAN_CONTROL,
    output logic      [7:0] RX_TX_LEVEL,
    output logic      [7:0] DWELL_HIGH,
    output logic      [7:0] DWELL_LOW,
    output logic            OSC_ENABLE,
    output logic      [1:0] REF_CLOCK_OUTPUT_DRIVE,
    output logic            PLL_POWER_ON,
    output logic            RX_POWER_ON,
    output logic            TX_POWER_ON,
    output logic            CARRIER_OUTPUT,
    output logic      [1:0] BIT_SPEED_SELECT,
    output logic      [3:0] ANTENNA_PORT_SELECT
);

    logic                      cs_s1, cs_s2;
    logic                      sclk_s1, sclk_s2, sclk_s3;
    logic                      mosi_s1, mosi_s2;
    logic                      key_s1, key_s2;
    logic                      rxout_s1, rxout_s2;
    logic                      dir_s1, dir_s2;
    ook_modem_pkg::spi_phase_t phase;
    logic [4:0]                bit_count;
    logic [14:0]               rx_shift;
    logic                      read_req;
    logic [6:0]                addr;
    logic [7:0]                tx_shift;
    logic [7:0]                config_control;
    logic [7:0]                port_select;
    logic                      sclk_rise, sclk_fall, cs_active;
    logic                      header_done, write_strobe;
    logic [6:0]                header_addr;
    logic [7:0]                write_data;
    logic [7:0]                read_value;
    logic [7:0]                next_config;
    logic [7:0]                next_port;
    logic                      next_power_off, next_standby, next_osc_on;

    // Isolation wins over the selection, so the one-hot never names a port then.
    function automatic logic [3:0] port_onehot(input logic isolate, input logic [1:0] sel);
        port_onehot = isolate ? 4'h0 : 4'(4'h1 << sel);
    endfunction

    // Two flops on every pin; the third SCLK stage only feeds edge detection.
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            cs_s1    <= 1'b1;
            cs_s2    <= 1'b1;
            sclk_s1  <= 1'b0;
            sclk_s2  <= 1'b0;
            sclk_s3  <= 1'b0;
            mosi_s1  <= 1'b0;
            mosi_s2  <= 1'b0;
            key_s1   <= 1'b1;
            key_s2   <= 1'b1;
            rxout_s1 <= 1'b1;
            rxout_s2 <= 1'b1;
            dir_s1   <= 1'b0;
            dir_s2   <= 1'b0;
        end else begin
            cs_s1    <= SPI_CS_N;
            cs_s2    <= cs_s1;
            sclk_s1  <= SPI_SCLK;
            sclk_s2  <= sclk_s1;
            sclk_s3  <= sclk_s2;
            mosi_s1  <= SPI_MOSI;
            mosi_s2  <= mosi_s1;
            key_s1   <= TRANSMIT_KEY_INPUT_N;
            key_s2   <= key_s1;
            rxout_s1 <= RX_OUT_N;
            rxout_s2 <= rxout_s1;
            dir_s1   <= DIRECTION;
            dir_s2   <= dir_s1;
        end
    end

    assign cs_active    = ~cs_s2;
    assign sclk_rise    = cs_active & sclk_s2 & ~sclk_s3;
    assign sclk_fall    = cs_active & ~sclk_s2 & sclk_s3;
    assign header_done  = sclk_rise && (bit_count == ook_modem_pkg::HEADER_LAST_BIT);
    assign header_addr  = {rx_shift[5:0], mosi_s2};
    assign write_data   = {rx_shift[6:0], mosi_s2};
    assign write_strobe = sclk_rise && (bit_count == ook_modem_pkg::FRAME_LAST_BIT)
                          && (phase == ook_modem_pkg::PHASE_DATA) && !read_req;

    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            phase     <= ook_modem_pkg::PHASE_IDLE;
            bit_count <= 5'h00;
            rx_shift  <= 15'h0000;
            read_req  <= 1'b0;
            addr      <= 7'h00;
        end else if (!cs_active) begin
            phase     <= ook_modem_pkg::PHASE_IDLE;
            bit_count <= 5'h00;
        end else if (sclk_rise) begin
            rx_shift  <= {rx_shift[13:0], mosi_s2};
            bit_count <= bit_count + 5'h01;
            case (phase)
                ook_modem_pkg::PHASE_IDLE: begin
                    phase <= ook_modem_pkg::PHASE_HEADER;
                end
                ook_modem_pkg::PHASE_HEADER: begin
                    if (header_done) begin
                        phase    <= ook_modem_pkg::PHASE_DATA;
                        read_req <= rx_shift[6];
                        addr     <= header_addr;
                    end
                end
                ook_modem_pkg::PHASE_DATA: begin
                    // Bits 17 to 32 are ignored; unless CS rises first, the 33rd starts a new frame.
                    if (bit_count == ook_modem_pkg::FRAME_LAST_BIT) begin
                        phase <= ook_modem_pkg::PHASE_IDLE;
                    end
                end
                default: begin
                    phase <= ook_modem_pkg::PHASE_IDLE;
                end
            endcase
        end
    end

    // Unmapped addresses read as zero.
    always_comb begin
        case (header_addr)
            ook_modem_pkg::ADDR_CONFIG:     read_value = config_control;
            ook_modem_pkg::ADDR_PORT:       read_value = port_select;
            ook_modem_pkg::ADDR_SCAN:       read_value = SCAN_CONTROL;
            ook_modem_pkg::ADDR_LEVEL:      read_value = RX_TX_LEVEL;
            ook_modem_pkg::ADDR_DWELL_HIGH: read_value = DWELL_HIGH;
            ook_modem_pkg::ADDR_DWELL_LOW:  read_value = DWELL_LOW;
            ook_modem_pkg::ADDR_RESULT:     read_value = SCAN_RESULT;
            ook_modem_pkg::ADDR_STATUS:     read_value = {5'h00, CARRIER_OUTPUT, dir_s2, rxout_s2};
            ook_modem_pkg::ADDR_PART:       read_value = PART_CODE;
            ook_modem_pkg::ADDR_REVISION:   read_value = REVISION_CODE;
            default:                        read_value = 8'h00;
        endcase
    end

    // MISO shifts on the falling SCLK so the host samples a settled bit.
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            SPI_MISO      <= 1'b0;
            SPI_MISO_OE_N <= 1'b1;
            tx_shift      <= 8'h00;
        end else if (!cs_active) begin
            SPI_MISO_OE_N <= 1'b1;
        end else if (header_done && (phase == ook_modem_pkg::PHASE_HEADER)) begin
            SPI_MISO      <= read_value[7];
            tx_shift      <= {read_value[6:0], 1'b0};
            SPI_MISO_OE_N <= ~rx_shift[6];
        // The fall right after the eighth rise keeps bit 7 up for the host's ninth rise;
        // shifting there would hand out bit 6 first and lose bit 7.
        end else if (sclk_fall && (phase == ook_modem_pkg::PHASE_DATA) && read_req
                     && (bit_count != 5'(ook_modem_pkg::HEADER_LAST_BIT + 5'h01))) begin
            SPI_MISO <= tx_shift[7];
            tx_shift <= {tx_shift[6:0], 1'b0};
        end
    end

    always_comb begin
        next_config = config_control;
        next_port   = port_select;
        if (write_strobe && (addr == ook_modem_pkg::ADDR_CONFIG)) begin
            next_config = write_data;
        end
        if (write_strobe && (addr == ook_modem_pkg::ADDR_PORT)) begin
            next_port = write_data & ook_modem_pkg::PORT_WRITE_MASK;
        end
    end

    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            config_control <= ook_modem_pkg::CONFIG_RESET;
            port_select    <= ook_modem_pkg::PORT_RESET;
            SCAN_CONTROL   <= ook_modem_pkg::SCAN_RESET;
            RX_TX_LEVEL    <= ook_modem_pkg::LEVEL_RESET;
            DWELL_HIGH     <= ook_modem_pkg::DWELL_HIGH_RESET;
            DWELL_LOW      <= ook_modem_pkg::DWELL_LOW_RESET;
        end else begin
            config_control <= next_config;
            port_select    <= next_port;
            if (write_strobe) begin
                case (addr)
                    ook_modem_pkg::ADDR_SCAN:       SCAN_CONTROL <= write_data;
                    ook_modem_pkg::ADDR_LEVEL:      RX_TX_LEVEL  <= write_data;
                    ook_modem_pkg::ADDR_DWELL_HIGH: DWELL_HIGH   <= write_data;
                    ook_modem_pkg::ADDR_DWELL_LOW:  DWELL_LOW    <= write_data;
                    default:                        ;
                endcase
            end
        end
    end

    assign next_power_off = next_config[ook_modem_pkg::CFG_POWER_OFF_BIT];
    assign next_standby   = next_config[ook_modem_pkg::CFG_STANDBY_BIT];
    assign next_osc_on    = ~next_power_off | next_config[ook_modem_pkg::CFG_OSC_KEEP_BIT];

    // Outputs are built from the next values so they move on the same edge as the register.
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            OSC_ENABLE             <= 1'b1;
            REF_CLOCK_OUTPUT_DRIVE <= ook_modem_pkg::CONFIG_RESET[ook_modem_pkg::CFG_DRIVE_LSB +: 2];
            PLL_POWER_ON           <= 1'b1;
            RX_POWER_ON            <= 1'b1;
            TX_POWER_ON            <= 1'b1;
            CARRIER_OUTPUT         <= 1'b0;
            BIT_SPEED_SELECT       <= ook_modem_pkg::CONFIG_RESET[ook_modem_pkg::CFG_SPEED_LSB +: 2];
            ANTENNA_PORT_SELECT    <= 4'h1;
        end else begin
            OSC_ENABLE <= next_osc_on;
            REF_CLOCK_OUTPUT_DRIVE <= next_osc_on ?
                next_config[ook_modem_pkg::CFG_DRIVE_LSB +: 2] : 2'h0;
            PLL_POWER_ON <= ~next_power_off;
            RX_POWER_ON  <= ~next_power_off;
            TX_POWER_ON  <= ~next_power_off & ~next_standby;
            CARRIER_OUTPUT <= ~next_power_off & ~next_standby
                & (next_config[ook_modem_pkg::CFG_CARRIER_ON_BIT] | ~key_s2);
            // The unused speed code leaves the digital divider where it was.
            if (next_config[ook_modem_pkg::CFG_SPEED_LSB +: 2] != ook_modem_pkg::SPEED_UNUSED) begin
                BIT_SPEED_SELECT <= next_config[ook_modem_pkg::CFG_SPEED_LSB +: 2];
            end
            // One flop edge moves straight to the new port, never through another.
            ANTENNA_PORT_SELECT <= port_onehot(next_port[ook_modem_pkg::PORT_ISOLATE_BIT],
                next_port[ook_modem_pkg::PORT_SELECT_LSB +: 2]);
        end
    end

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RESETN);

    sequence port_write_seq;
        write_strobe && (addr == ook_modem_pkg::ADDR_PORT);
    endsequence

    sequence config_write_seq;
        write_strobe && (addr == ook_modem_pkg::ADDR_CONFIG);
    endsequence

    AST_OSC_RETAIN: assert property (
        OSC_ENABLE == (!config_control[6] || config_control[7]))
        else $error("Oscillator enable does not match power-down and retention bits.");

    AST_POWER_OFF: assert property (
        config_control[6] |-> !PLL_POWER_ON && !RX_POWER_ON && !TX_POWER_ON && !CARRIER_OUTPUT)
        else $error("Power-down left a circuit running.");

    AST_STANDBY: assert property (
        config_control[5] && !config_control[6] |-> PLL_POWER_ON && RX_POWER_ON && !TX_POWER_ON)
        else $error("Standby did not switch off only the transmitter.");

    AST_CARRIER: assert property (
        CARRIER_OUTPUT == (TX_POWER_ON && (config_control[4] || !$past(key_s2))))
        else $error("Carrier output neither forced nor following the key pin.");

    AST_DRIVE_LEVEL: assert property (
        REF_CLOCK_OUTPUT_DRIVE == (OSC_ENABLE ? config_control[3:2] : 2'h0))
        else $error("Reference clock drive does not match its field.");

    AST_SPEED_APPLY: assert property (
        config_write_seq ##1 (config_control[1:0] != 2'h3) |-> BIT_SPEED_SELECT == config_control[1:0])
        else $error("Bit speed not applied after a config write.");

    AST_SPEED_UNUSED: assert property (
        config_control[1:0] == 2'h3 |-> $stable(BIT_SPEED_SELECT))
        else $error("Unused speed code changed the divider.");

    AST_ISOLATE: assert property (
        port_select[2] |-> ANTENNA_PORT_SELECT == 4'h0)
        else $error("An RF port is joined while isolated.");

    AST_PORT_CHOICE: assert property (
        !port_select[2] |-> ANTENNA_PORT_SELECT == 4'(4'h1 << port_select[1:0]))
        else $error("Joined RF port differs from the selection.");

    AST_PORT_WRITE: assert property (
        port_write_seq |=> port_select == ($past(write_data) & 8'h07)
            && ANTENNA_PORT_SELECT == port_onehot($past(write_data[2]), $past(write_data[1:0])))
        else $error("Port write not applied at the next edge.");

    AST_NO_GLITCH: assert property (
        $onehot0(ANTENNA_PORT_SELECT) && (!$changed(ANTENNA_PORT_SELECT) || $past(write_strobe)))
        else $error("Port selection moved without a write or named two ports.");

    AST_MISO_RELEASE: assert property (
        !cs_active |=> SPI_MISO_OE_N)
        else $error("MISO still driven after chip select went high.");

endmodule

// >>> ook_modem_config_registers_tb.sv
// Self-checking bench for the modem configuration register bank.
// Assumes the SPI host model drives the serial port; other pins are driven here.
`timescale 1ns/1ps

module ook_modem_config_registers_tb;
    localparam logic [7:0] PART = 8'h3c; // Arbitrary value.
    localparam logic [7:0] REV  = 8'hc3; // Arbitrary value.

    logic       clock = 1'b0;
    logic       resetn, cs_n, sclk, mosi, miso, miso_oe_n, key_n, rx_out_n, direction;
    logic [7:0] scan_result, scan_control, rx_tx_level, dwell_high, dwell_low;
    logic       osc_enable, pll_on, rx_on, tx_on, carrier;
    logic [1:0] drive, speed;
    logic [3:0] antenna, last_ant;
    int         n_mismatch = 0;
    int         check_count = 0;
    int         cycles = 0;
    int         n_change = 0;

    always #50 clock = ~clock;

    ook_modem_config_registers #(.PART_CODE(PART), .REVISION_CODE(REV)) dut_u (
        .CLOCK(clock), .RESETN(resetn), .SPI_CS_N(cs_n), .SPI_SCLK(sclk), .SPI_MOSI(mosi),
        .SPI_MISO(miso), .SPI_MISO_OE_N(miso_oe_n), .TRANSMIT_KEY_INPUT_N(key_n),
        .RX_OUT_N(rx_out_n), .DIRECTION(direction), .SCAN_RESULT(scan_result),
        .SCAN_CONTROL(scan_control), .RX_TX_LEVEL(rx_tx_level), .DWELL_HIGH(dwell_high),
        .DWELL_LOW(dwell_low), .OSC_ENABLE(osc_enable), .REF_CLOCK_OUTPUT_DRIVE(drive),
        .PLL_POWER_ON(pll_on), .RX_POWER_ON(rx_on), .TX_POWER_ON(tx_on),
        .CARRIER_OUTPUT(carrier), .BIT_SPEED_SELECT(speed), .ANTENNA_PORT_SELECT(antenna));

    ook_spi_host_model host_u (
        .CLOCK(clock), .CS_N(cs_n), .SCLK(sclk), .MOSI(mosi), .MISO(miso),
        .MISO_OE_N(miso_oe_n));

    task automatic complete_run();
        if (n_mismatch == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Port changes are counted on settled values to catch a selection passing other ports.
    always @(negedge clock) begin
        cycles++;
        if (antenna !== last_ant) begin
            n_change++;
        end
        last_ant = antenna;
        if (cycles == 20000) begin
            n_mismatch++;
            complete_run();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] d, input int nbits);
        logic [7:0] r;
        host_u.xfer(1'b0, a, d, nbits, r);
    endtask

    task automatic rdc(input logic [6:0] a, input logic [7:0] exp);
        logic [7:0] r;
        host_u.xfer(1'b1, a, 8'h00, 16, r);
        check(32'(r), 32'(exp));
    endtask

    task automatic check_cfg(input logic [7:0] c, input logic [1:0] sp);
        logic osc, p;
        osc = c[7] | ~c[6];
        p = ~c[6];
        check(32'({osc_enable, drive, pll_on, rx_on, tx_on, carrier, speed}),
              32'({osc, osc ? c[3:2] : 2'h0, p, p, p & ~c[5], p & ~c[5] & (c[4] | ~key_n),
                   sp}));
    endtask

    task automatic do_reset();
        @(negedge clock);
        resetn = 1'b0;
        repeat (16) @(negedge clock);
        resetn = 1'b1;
        repeat (4) @(negedge clock);
    endtask

    task automatic t_reset();
        check_cfg(8'h84, 2'h0);
        check(32'(antenna), 32'h1);
        check({scan_control, rx_tx_level, dwell_high, dwell_low}, 32'h50b70f00);
        rdc(7'h00, 8'h84);
        rdc(7'h01, 8'h00);
    endtask

    task automatic t_config();
        logic [7:0] vals [6] = '{8'h40, 8'hc8, 8'h2d, 8'h92, 8'h13, 8'h00};
        logic [1:0] sps [6] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h2, 2'h0};
        for (int i = 0; i < 6; i++) begin
            wr(7'h00, vals[i], 16);
            check_cfg(vals[i], sps[i]);
            rdc(7'h00, vals[i]);
        end
        key_n = 1'b0;
        repeat (5) @(negedge clock);
        check_cfg(8'h00, 2'h0);
        key_n = 1'b1;
        repeat (5) @(negedge clock);
        check_cfg(8'h00, 2'h0);
    endtask

    task automatic port_set(input logic [7:0] d);
        logic [3:0] old_ant, exp_ant;
        old_ant = d[2] ? 4'h0 : 4'h1 << d[1:0];
        exp_ant = d[2] ? 4'h0 : 4'h1 << d[1:0];
        old_ant = antenna;
        n_change = 0;
        wr(7'h01, d, 16);
        check(32'(antenna), 32'(exp_ant));
        check(32'(n_change), 32'(old_ant !== exp_ant));
    endtask

    task automatic t_port();
        for (int i = 0; i < 8; i++) begin
            port_set(8'(i));
        end
        port_set(8'h00);
        port_set(8'h03);
        wr(7'h01, 8'h01, 15);
        check(32'(antenna), 32'h8);
        port_set(8'hfe);
        rdc(7'h01, 8'h06);
    endtask

    task automatic t_misc();
        for (int a = 2; a < 6; a++) begin
            wr(7'(a), 8'(8'h11 * a), 16);
            rdc(7'(a), 8'(8'h11 * a));
            check(32'(a == 2 ? scan_control : a == 3 ? rx_tx_level :
                      a == 4 ? dwell_high : dwell_low), 32'(8'h11 * a));
        end
        wr(7'h08, 8'h00, 16);
        rdc(7'h08, PART);
        rdc(7'h09, REV);
        rdc(7'h0a, 8'h00);
        rdc(7'h06, 8'ha5);
        direction = 1'b1;
        rx_out_n = 1'b0;
        wr(7'h00, 8'h94, 16);
        rdc(7'h07, 8'h06);
    endtask

    initial begin
        resetn = 1'b0;
        key_n = 1'b1;
        rx_out_n = 1'b1;
        direction = 1'b0;
        scan_result = 8'ha5;
        last_ant = 4'h0;
        do_reset();
        t_reset();
        t_config();
        t_port();
        t_misc();
        do_reset();
        t_reset();
        complete_run();
    end
endmodule

// >>> ook_modem_pkg.sv
// Shared constants of the modem configuration register bank.
// Assumes a single 10 MHz system clock and a host on the serial port.
package ook_modem_pkg;

    // Register addresses as seen in the serial header.
    localparam logic [6:0] ADDR_CONFIG     = 7'h00;
    localparam logic [6:0] ADDR_PORT       = 7'h01;
    localparam logic [6:0] ADDR_SCAN       = 7'h02;
    localparam logic [6:0] ADDR_LEVEL      = 7'h03;
    localparam logic [6:0] ADDR_DWELL_HIGH = 7'h04;
    localparam logic [6:0] ADDR_DWELL_LOW  = 7'h05;
    localparam logic [6:0] ADDR_RESULT     = 7'h06;
    localparam logic [6:0] ADDR_STATUS     = 7'h07;
    localparam logic [6:0] ADDR_PART       = 7'h08;
    localparam logic [6:0] ADDR_REVISION   = 7'h09;

    // Field positions of config_control.
    localparam int CFG_OSC_KEEP_BIT   = 7;
    localparam int CFG_POWER_OFF_BIT  = 6;
    localparam int CFG_STANDBY_BIT    = 5;
    localparam int CFG_CARRIER_ON_BIT = 4;
    localparam int CFG_DRIVE_LSB      = 2;
    localparam int CFG_SPEED_LSB      = 0;

    // Field positions of port_select.
    localparam int PORT_ISOLATE_BIT = 2;
    localparam int PORT_SELECT_LSB  = 0;

    // Values after reset, then the port write mask and the unused speed code.
    localparam logic [7:0] CONFIG_RESET     = 8'h84;
    localparam logic [7:0] PORT_RESET       = 8'h00;
    localparam logic [7:0] SCAN_RESET       = 8'h50;
    localparam logic [7:0] LEVEL_RESET      = 8'hb7;
    localparam logic [7:0] DWELL_HIGH_RESET = 8'h0f;
    localparam logic [7:0] DWELL_LOW_RESET  = 8'h00;
    localparam logic [7:0] PORT_WRITE_MASK  = 8'h07;
    localparam logic [1:0] SPEED_UNUSED     = 2'h3;

    // Serial frame: one read flag, seven address bits, eight data bits.
    localparam logic [4:0] HEADER_LAST_BIT = 5'h07;
    localparam logic [4:0] FRAME_LAST_BIT  = 5'h0f;

    typedef enum logic [1:0] {
        PHASE_IDLE,
        PHASE_HEADER,
        PHASE_DATA
    } spi_phase_t;

endpackage

// >>> ook_spi_host_model.sv
// Behavioural SPI host that frames register accesses for the modem register bank.
// Assumes the bank samples SCLK with CLOCK, so each SCLK phase lasts four CLOCK periods.
`timescale 1ns/1ps

module ook_spi_host_model (
    input  wire logic CLOCK,
    output logic      CS_N,
    output logic      SCLK,
    output logic      MOSI,
    input  wire logic MISO,
    input  wire logic MISO_OE_N
);
    initial begin
        CS_N = 1'b1;
        SCLK = 1'b0;
        MOSI = 1'b0;
    end

    task automatic half_bit();
        repeat (4) @(negedge CLOCK);
    endtask

    // Sends nbits of a frame; fewer than 16 aborts the frame by raising CS_N early.
    task automatic xfer(input logic rd, input logic [6:0] addr, input logic [7:0] wdata,
                        input int nbits, output logic [7:0] rdata);
        logic [15:0] frame;
        frame = {rd, addr, wdata};
        rdata = 8'h00;
        @(negedge CLOCK);
        CS_N = 1'b0;
        for (int i = 15; i >= 16 - nbits; i--) begin
            MOSI = frame[i];
            half_bit();
            // A released MISO must not pass for data, so it reads as unknown.
            if (i < 8) begin
                rdata = {rdata[6:0], MISO_OE_N ? 1'bx : MISO};
            end
            SCLK = 1'b1;
            half_bit();
            SCLK = 1'b0;
        end
        half_bit();
        CS_N = 1'b1;
        // Outside a frame the data line is flipped once so nothing relies on a stale level.
        MOSI = ~MOSI;
        half_bit();
    endtask
endmodule
